// *** cwg_pkg.sv ***
// Constants, register map and carrier types of the complementary waveform unit
// Operation
// - Six output modes chosen by the three-bit mode field of the control register
// - Half-bridge: A carries input, B its inverse, dead band between transitions
// - Half-bridge: C and D repeat A and B with their own polarity bits
// - Push-pull: successive input pulses alternate between outputs A and B
// - Push-pull sequencer returns to start when disabled or shut down
// - First pulse after sequencer reset advances it and appears on output A
// - Push-pull: C copies A, D copies B, each with own polarity bit
// - Forward full-bridge: A active, B and C inactive, D follows input
// - Reverse full-bridge: C active, A and D inactive, B follows input
// - Full-bridge dead band applies only when direction changes
// - Toggling lowest mode bit switches direction without disabling the unit
// - All modes support auto-shutdown with sources, auto-restart and override levels
// - Independent clocked 6-bit rising and falling dead-band counters with own enables
// - Steering changes act immediately or at next rising event, per mode
// - Steering enable set passes data through polarity, clear drives static level
// - Synchronous steering double-buffers enable bits until the rising event
package cwg_pkg;

	// ==================================================
	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_POL = 8'h04;
	localparam logic [7:0] OFS_STEER = 8'h08;
	localparam logic [7:0] OFS_DB_RISE = 8'h0c;
	localparam logic [7:0] OFS_DB_FALL = 8'h10;
	localparam logic [7:0] OFS_SHUT = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_INT_STAT = 8'h1c;
	localparam logic [7:0] OFS_INT_MASK = 8'h20;

	// ==================================================
	// Field positions
	localparam int MODE_EN_BIT = 7;
	localparam int DB_EN_BIT = 7;
	localparam int SHUT_RESTART_BIT = 0;
	localparam int SHUT_PIN_EN_BIT = 1;
	localparam int SHUT_SW_BIT = 2;
	localparam int SHUT_OVR_LSB = 4;
	localparam int ST_SHUT_BIT = 0;
	localparam int ST_SEQ_BIT = 1;
	localparam int ST_DIR_BIT = 2;
	localparam int ST_DEAD_BIT = 3;
	localparam int EV_SHUT = 0;
	localparam int EV_RESTART = 1;
	localparam int EV_DIR = 2;
	localparam int DB_W = 6;
	localparam int EV_W = 3;

	// ==================================================
	// Reset values
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [EV_W-1:0] RST_EV = 3'h0;
	localparam logic [DB_W-1:0] DB_ZERO = 6'h00;
	localparam logic [DB_W-1:0] DB_ONE = 6'h01;

	// ==================================================
	// Mode field encodings
	localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
	localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
	localparam logic [2:0] MODE_FULL_FWD = 3'h2;
	localparam logic [2:0] MODE_FULL_REV = 3'h3;
	localparam logic [2:0] MODE_HALF = 3'h4;
	localparam logic [2:0] MODE_PUSH_PULL = 3'h5;
	localparam logic [1:0] MODE_HI_STEER = 2'h0;
	localparam logic [1:0] MODE_HI_FULL = 2'h1;

	// Full-bridge direction sequencer, one-hot
	typedef enum logic [2:0] {
		DIR_FWD = 3'h1,
		DIR_REV = 3'h2,
		DIR_DEAD = 3'h4
	} dir_state_t;

	// One bit per output, a in the low bit
	typedef struct packed {
		logic d;
		logic c;
		logic b;
		logic a;
	} drive_t;

	// APB response carried as one group
	typedef struct packed {
		logic [31:0] rdata;
		logic err;
	} apb_resp_t;

endpackage

// *** cwg_unit.sv ***
// Complementary waveform unit with APB register access
`timescale 1ns/10ps
module complementary_waveform_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic modulating_input_i,
	input wire logic shutdown_i,
	output logic output_a_o,
	output logic output_b_o,
	output logic output_c_o,
	output logic output_d_o,
	output logic irq_o
);

	// ==================================================
	// Event vector width, a short local copy for the declarations below
	localparam int EV_W_L = cwg_pkg::EV_W;

	// Register state
	logic [7:0] mode_control_reg, next_mode_control_reg;
	logic [7:0] output_polarity_reg, next_output_polarity_reg;
	logic [7:0] output_steering_control, next_output_steering_control;
	logic [7:0] db_rise_reg, next_db_rise_reg;
	logic [7:0] db_fall_reg, next_db_fall_reg;
	logic [7:0] shut_ctrl_reg, next_shut_ctrl_reg;
	logic [EV_W_L-1:0] int_stat, next_int_stat;
	logic [EV_W_L-1:0] int_mask, next_int_mask;
	cwg_pkg::apb_resp_t resp, next_resp;

	// ==================================================
	// Core state
	logic data_q, next_data_q;
	logic true_q, next_true_q;
	logic comp_q, next_comp_q;
	logic [cwg_pkg::DB_W-1:0] rise_cnt, next_rise_cnt;
	logic [cwg_pkg::DB_W-1:0] fall_cnt, next_fall_cnt;
	logic [cwg_pkg::DB_W-1:0] dir_cnt, next_dir_cnt;
	cwg_pkg::dir_state_t dir_state, next_dir_state;
	logic seq_b, next_seq_b;
	logic shut_q, next_shut_q;
	logic [3:0] steer_shadow, next_steer_shadow;
	cwg_pkg::drive_t out_q, next_out_q;

	// Derived control
	logic enable, rise_ev, fall_ev, setup_ph, wr_en, shut_src, manual_clear;
	logic [2:0] mode;
	logic [cwg_pkg::DB_W-1:0] rise_val, fall_val;
	logic rise_en, fall_en, is_steer, is_full, want_rev;
	logic [EV_W_L-1:0] events, w1c;
	cwg_pkg::drive_t act, pol, ovr, steer_val, steer_sel;

	// Address match against one register word
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	// Synchronous steering decode, shared by the shadow load and the enable select
	function automatic logic sync_steer(input logic [2:0] m);
		sync_steer = (m == cwg_pkg::MODE_STEER_SYNC);
	endfunction

	// ==================================================
	// Field extraction
	assign enable = mode_control_reg[cwg_pkg::MODE_EN_BIT];
	assign mode = mode_control_reg[2:0];
	assign is_steer = (mode[2:1] == cwg_pkg::MODE_HI_STEER);
	assign is_full = (mode[2:1] == cwg_pkg::MODE_HI_FULL);
	assign want_rev = mode[0];
	assign rise_val = db_rise_reg[cwg_pkg::DB_W-1:0];
	assign fall_val = db_fall_reg[cwg_pkg::DB_W-1:0];
	assign rise_en = db_rise_reg[cwg_pkg::DB_EN_BIT];
	assign fall_en = db_fall_reg[cwg_pkg::DB_EN_BIT];
	assign pol = output_polarity_reg[3:0];
	assign steer_val = output_steering_control[7:4];
	assign ovr = shut_ctrl_reg[cwg_pkg::SHUT_OVR_LSB+3:cwg_pkg::SHUT_OVR_LSB];
	assign rise_ev = modulating_input_i & ~data_q;
	assign fall_ev = ~modulating_input_i & data_q;
	assign setup_ph = psel_i & ~penable_i;
	assign wr_en = psel_i & penable_i & pwrite_i;
	assign w1c = (wr_en && hit(paddr_i, cwg_pkg::OFS_INT_STAT)) ? pwdata_i[EV_W_L-1:0] : '0;
	assign manual_clear = wr_en && hit(paddr_i, cwg_pkg::OFS_STATUS) && pwdata_i[cwg_pkg::ST_SHUT_BIT];

	// Fault sources: external pin when enabled, or a software request
	assign shut_src = (shutdown_i & shut_ctrl_reg[cwg_pkg::SHUT_PIN_EN_BIT]) |
		shut_ctrl_reg[cwg_pkg::SHUT_SW_BIT];

	// Zero-wait slave: read data is captured in setup, so pready may be tied high
	assign pready_o = 1'b1;
	assign prdata_o = resp.rdata;
	assign pslverr_o = resp.err;
	assign irq_o = |(int_stat & int_mask);
	assign output_a_o = out_q.a;
	assign output_b_o = out_q.b;
	assign output_c_o = out_q.c;
	assign output_d_o = out_q.d;

	// ==================================================
	// Register file next values and read mux
	always_comb begin
		next_mode_control_reg = mode_control_reg;
		next_output_polarity_reg = output_polarity_reg;
		next_output_steering_control = output_steering_control;
		next_db_rise_reg = db_rise_reg;
		next_db_fall_reg = db_fall_reg;
		next_shut_ctrl_reg = shut_ctrl_reg;
		next_int_mask = int_mask;
		next_resp = resp;
		// Set wins over a clear arriving in the same cycle
		next_int_stat = (int_stat & ~w1c) | events;
		if (wr_en) begin
			case (paddr_i)
				cwg_pkg::OFS_MODE: next_mode_control_reg = pwdata_i[7:0];
				cwg_pkg::OFS_POL: next_output_polarity_reg = {4'h0, pwdata_i[3:0]};
				cwg_pkg::OFS_STEER: next_output_steering_control = pwdata_i[7:0];
				cwg_pkg::OFS_DB_RISE: next_db_rise_reg = pwdata_i[7:0] & 8'hbf;
				cwg_pkg::OFS_DB_FALL: next_db_fall_reg = pwdata_i[7:0] & 8'hbf;
				cwg_pkg::OFS_SHUT: next_shut_ctrl_reg = pwdata_i[7:0] & 8'hf7;
				cwg_pkg::OFS_INT_MASK: next_int_mask = pwdata_i[EV_W_L-1:0];
				default: next_int_mask = int_mask;
			endcase
		end
		if (setup_ph) begin
			next_resp.err = 1'b0;
			case (paddr_i)
				cwg_pkg::OFS_MODE: next_resp.rdata = {24'h0, mode_control_reg};
				cwg_pkg::OFS_POL: next_resp.rdata = {24'h0, output_polarity_reg};
				cwg_pkg::OFS_STEER: next_resp.rdata = {24'h0, output_steering_control};
				cwg_pkg::OFS_DB_RISE: next_resp.rdata = {24'h0, db_rise_reg};
				cwg_pkg::OFS_DB_FALL: next_resp.rdata = {24'h0, db_fall_reg};
				cwg_pkg::OFS_SHUT: next_resp.rdata = {24'h0, shut_ctrl_reg};
				cwg_pkg::OFS_STATUS: next_resp.rdata = {28'h0, dir_state == cwg_pkg::DIR_DEAD,
					dir_state == cwg_pkg::DIR_REV, seq_b, shut_q};
				cwg_pkg::OFS_INT_STAT: next_resp.rdata = {29'h0, int_stat};
				cwg_pkg::OFS_INT_MASK: next_resp.rdata = {29'h0, int_mask};
				default: begin
					next_resp.rdata = 32'h0;
					next_resp.err = 1'b1;
				end
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_control_reg <= cwg_pkg::RST_REG8;
			output_polarity_reg <= cwg_pkg::RST_REG8;
			output_steering_control <= cwg_pkg::RST_REG8;
			db_rise_reg <= cwg_pkg::RST_REG8;
			db_fall_reg <= cwg_pkg::RST_REG8;
			shut_ctrl_reg <= cwg_pkg::RST_REG8;
			int_stat <= cwg_pkg::RST_EV;
			int_mask <= cwg_pkg::RST_EV;
			resp <= '0;
		end else begin
			mode_control_reg <= next_mode_control_reg;
			output_polarity_reg <= next_output_polarity_reg;
			output_steering_control <= next_output_steering_control;
			db_rise_reg <= next_db_rise_reg;
			db_fall_reg <= next_db_fall_reg;
			shut_ctrl_reg <= next_shut_ctrl_reg;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			resp <= next_resp;
		end
	end

	// ==================================================
	// Dead band counters and the non-overlapped true and complement levels
	always_comb begin
		next_data_q = modulating_input_i;

		// Rising dead band delays the true rise; falling one delays the complement rise
		next_rise_cnt = rise_cnt;
		if (!modulating_input_i)
			next_rise_cnt = cwg_pkg::DB_ZERO;
		else if (rise_ev && rise_en)
			next_rise_cnt = rise_val;
		else if (rise_cnt != cwg_pkg::DB_ZERO)
			next_rise_cnt = rise_cnt - cwg_pkg::DB_ONE;
		next_fall_cnt = fall_cnt;
		if (modulating_input_i)
			next_fall_cnt = cwg_pkg::DB_ZERO;
		else if (fall_ev && fall_en)
			next_fall_cnt = fall_val;
		else if (fall_cnt != cwg_pkg::DB_ZERO)
			next_fall_cnt = fall_cnt - cwg_pkg::DB_ONE;
		// Non-overlap: each side turns on only after its own delay expires
		next_true_q = modulating_input_i && (next_rise_cnt == cwg_pkg::DB_ZERO);
		next_comp_q = !modulating_input_i && (next_fall_cnt == cwg_pkg::DB_ZERO);
	end

	// ==================================================
	// Shutdown, push-pull and direction sequencers; every event pulse is raised here
	always_comb begin
		events = '0;

		// Shutdown latch; a live source keeps it set against auto-restart and manual clear, but disabling the unit clears it
		next_shut_q = shut_q;
		if (!enable)
			next_shut_q = 1'b0;
		else if (shut_src)
			next_shut_q = 1'b1;
		else if (shut_q && shut_ctrl_reg[cwg_pkg::SHUT_RESTART_BIT] && rise_ev)
			next_shut_q = 1'b0;
		else if (shut_q && manual_clear)
			next_shut_q = 1'b0;
		events[cwg_pkg::EV_SHUT] = next_shut_q & ~shut_q;
		events[cwg_pkg::EV_RESTART] = shut_q & ~next_shut_q & enable;

		// Push-pull steering bit: reset points at B so the first rise selects A
		next_seq_b = seq_b;
		if (!enable || next_shut_q)
			next_seq_b = 1'b1;
		else if (rise_ev)
			next_seq_b = ~seq_b;

		// Full-bridge direction with dead time only on reversal
		next_dir_state = dir_state;
		next_dir_cnt = dir_cnt;
		case (dir_state)
			cwg_pkg::DIR_FWD: begin
				if (!is_full || !enable)
					next_dir_state = want_rev ? cwg_pkg::DIR_REV : cwg_pkg::DIR_FWD;
				else if (want_rev) begin
					next_dir_state = cwg_pkg::DIR_DEAD;
					next_dir_cnt = rise_val;
				end
			end
			cwg_pkg::DIR_REV: begin
				if (!is_full || !enable)
					next_dir_state = want_rev ? cwg_pkg::DIR_REV : cwg_pkg::DIR_FWD;
				else if (!want_rev) begin
					next_dir_state = cwg_pkg::DIR_DEAD;
					next_dir_cnt = fall_val;
				end
			end
			cwg_pkg::DIR_DEAD: begin
				if (!is_full || !enable || dir_cnt == cwg_pkg::DB_ZERO) begin
					next_dir_state = want_rev ? cwg_pkg::DIR_REV : cwg_pkg::DIR_FWD;
					next_dir_cnt = cwg_pkg::DB_ZERO;
					events[cwg_pkg::EV_DIR] = is_full & enable;
				end else
					next_dir_cnt = dir_cnt - cwg_pkg::DB_ONE;
			end
			default: begin
				next_dir_state = cwg_pkg::DIR_FWD;
				next_dir_cnt = cwg_pkg::DB_ZERO;
			end
		endcase
	end

	// ==================================================
	// Steering shadow and output stage
	always_comb begin
		// Steering enables: live in async mode, taken at the rising event in sync mode
		if (sync_steer(mode))
			next_steer_shadow = rise_ev ? output_steering_control[3:0] : steer_shadow;
		else
			next_steer_shadow = output_steering_control[3:0];
		// Sync mode drives from the shadow so a half-written pattern never reaches the pins
		steer_sel = sync_steer(mode) ? steer_shadow : output_steering_control[3:0];

		// Active-sense drive per mode, before polarity
		act = '0;
		case (mode)
			cwg_pkg::MODE_HALF: act = {comp_q, true_q, comp_q, true_q};
			cwg_pkg::MODE_PUSH_PULL: begin
				act.a = true_q & ~seq_b;
				act.b = true_q & seq_b;
				act.c = act.a;
				act.d = act.b;
			end
			cwg_pkg::MODE_FULL_FWD, cwg_pkg::MODE_FULL_REV: begin
				if (dir_state == cwg_pkg::DIR_FWD)
					act = {data_q, 1'b0, 1'b0, 1'b1};
				else if (dir_state == cwg_pkg::DIR_REV)
					act = {1'b0, 1'b1, data_q, 1'b0};
			end
			default: act = {data_q, data_q, data_q, data_q};
		endcase

		// Pin levels: disabled idles inactive, shutdown drives override levels
		if (!enable)
			next_out_q = pol;
		else if (shut_q)
			next_out_q = ovr;
		else if (is_steer)
			next_out_q = (act ^ pol) & steer_sel | steer_val & ~steer_sel;
		else
			next_out_q = act ^ pol;
	end

	// ==================================================
	// Core storage, one register group per next-value process
	// Dead band stage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_q <= 1'b0;
			true_q <= 1'b0;
			comp_q <= 1'b0;
			rise_cnt <= cwg_pkg::DB_ZERO;
			fall_cnt <= cwg_pkg::DB_ZERO;
		end else begin
			data_q <= next_data_q;
			true_q <= next_true_q;
			comp_q <= next_comp_q;
			rise_cnt <= next_rise_cnt;
			fall_cnt <= next_fall_cnt;
		end
	end

	// Sequencers; the push-pull bit resets pointing at B so the first pulse lands on A
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dir_cnt <= cwg_pkg::DB_ZERO;
			dir_state <= cwg_pkg::DIR_FWD;
			seq_b <= 1'b1;
			shut_q <= 1'b0;
		end else begin
			dir_cnt <= next_dir_cnt;
			dir_state <= next_dir_state;
			seq_b <= next_seq_b;
			shut_q <= next_shut_q;
		end
	end

	// Shadow and pin registers; pins reset low, the idle level with clear polarity
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			steer_shadow <= 4'h0;
			out_q <= '0;
		end else begin
			steer_shadow <= next_steer_shadow;
			out_q <= next_out_q;
		end
	end

endmodule

// *** cwg_bridge_model.sv ***
// Fault comparator model of the external bridge driver stage
`timescale 1ns/10ps
module bridge_fault_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic trip_i,
	output logic fault_o
);
	// ==========
	// Fault level
	// Registered like a comparator behind a sync stage, so it lags the trip by one edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fault_o <= 1'b0;
		end else begin
			fault_o <= trip_i;
		end
	end
endmodule

// *** cwg_assertions.sv ***
// Port-level checker for the complementary waveform unit
`timescale 1ns/10ps
module cwg_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic modulating_input_i,
	input wire logic shutdown_i,
	input wire logic output_a_o,
	input wire logic output_b_o,
	input wire logic output_c_o,
	input wire logic output_d_o,
	input wire logic irq_o
);
	logic [7:0] mode;
	logic [3:0] pol;
	logic [7:0] steer;
	logic [1:0] dbn;
	logic clean;
	logic in_q;
	logic in_qq;
	logic [21:0] cfg_q;
	logic [21:0] cfg_qq;
	logic [21:0] cfg_q3;
	logic [3:0] outs;
	logic [3:0] dat;
	logic st;
	// ==========
	// Shadow of the written settings
	// Checks wait for settings to stand three edges: pins lag a write, a reversal adds a dead cycle
	assign outs = {output_d_o, output_c_o, output_b_o, output_a_o};
	assign dat = {4{in_qq}} ^ pol;
	assign st = ({mode, pol, steer, dbn} == cfg_q) && (cfg_q == cfg_qq) && (cfg_qq == cfg_q3) && clean &&
		(dbn == 2'h0);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{mode, pol, steer, dbn, cfg_q, cfg_qq, cfg_q3, in_q, in_qq} <= '0;
			clean <= 1'b1;
		end else begin
			in_q <= modulating_input_i;
			in_qq <= in_q;
			cfg_q <= {mode, pol, steer, dbn};
			cfg_qq <= cfg_q;
			cfg_q3 <= cfg_qq;
			if (shutdown_i) clean <= 1'b0;
			if (psel_i && penable_i && pwrite_i && pready_o) begin
				case (paddr_i)
					8'h00: mode <= pwdata_i[7:0];
					8'h04: pol <= pwdata_i[3:0];
					8'h08: steer <= pwdata_i[7:0];
					8'h0c: dbn[0] <= |pwdata_i[7:0];
					8'h10: dbn[1] <= |pwdata_i[7:0];
					8'h14: clean <= 1'b0;
					default: ;
				endcase
			end
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_pready;
		psel_i |-> pready_o;
	endproperty
	property p_err;
		psel_i && penable_i |-> pslverr_o == (paddr_i > 8'h20 || paddr_i[1:0] != 2'h0);
	endproperty
	property p_off;
		st && !mode[7] |-> outs == pol;
	endproperty
	property p_half;
		st && mode == 8'h84 |-> outs == (dat ^ 4'ha);
	endproperty
	property p_fwd;
		st && mode == 8'h82 |-> outs == {dat[3], pol[2], pol[1], ~pol[0]};
	endproperty
	property p_rev;
		st && mode == 8'h83 |-> outs == {pol[3], ~pol[2], dat[1], pol[0]};
	endproperty
	property p_steer;
		st && mode == 8'h80 |-> outs == ((dat & steer[3:0]) | (steer[7:4] & ~steer[3:0]));
	endproperty
	property p_ppc;
		st && mode == 8'h85 |-> (outs[3:2] ^ pol[3:2]) == (outs[1:0] ^ pol[1:0]);
	endproperty
	property p_nov;
		st && (mode == 8'h84 || mode == 8'h85) |-> !((outs[0] ^ pol[0]) && (outs[1] ^ pol[1]));
	endproperty
	a_pready: assert property (p_pready) else $error("pready low");
	a_err: assert property (p_err) else $error("slave error wrong");
	a_off: assert property (p_off) else $error("disabled pins active");
	a_half: assert property (p_half) else $error("half-bridge pins wrong");
	a_fwd: assert property (p_fwd) else $error("forward pins wrong");
	a_rev: assert property (p_rev) else $error("reverse pins wrong");
	a_steer: assert property (p_steer) else $error("steering pins wrong");
	a_ppc: assert property (p_ppc) else $error("push-pull copies wrong");
	a_nov: assert property (p_nov) else $error("outputs overlap");
	c_half: cover property (mode == 8'h84 && output_a_o);
	c_rev: cover property (mode == 8'h83 && output_b_o);
	c_irq: cover property (irq_o);
endmodule
bind complementary_waveform_unit cwg_checker chk (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .modulating_input_i(modulating_input_i), .shutdown_i(shutdown_i),
	.output_a_o(output_a_o), .output_b_o(output_b_o), .output_c_o(output_c_o), .output_d_o(output_d_o),
	.irq_o(irq_o));

// *** tb_complementary_waveform_unit.sv ***
// Self-checking bench for the complementary waveform unit
`timescale 1ns/10ps
module tb_complementary_waveform_unit;
	logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, trip = 0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic pready_o, pslverr_o, modulating_input_i = 0, shutdown_i;
	logic output_a_o, output_b_o, output_c_o, output_d_o, irq_o;
	int err_total = 0, cmp_count = 0;
	complementary_waveform_unit dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .modulating_input_i(modulating_input_i), .shutdown_i(shutdown_i),
		.output_a_o(output_a_o), .output_b_o(output_b_o), .output_c_o(output_c_o), .output_d_o(output_d_o),
		.irq_o(irq_o));
	bridge_fault_model load (.clk_i(clk_i), .rst_i(rst_i), .trip_i(trip), .fault_o(shutdown_i));
	initial forever #10 clk_i = ~clk_i;
	// ==========
	// Tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Holds the request until pready is seen; no wait count assumed
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input string n, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(n, x, r);
	endtask
	// Pins follow the input two edges later, so three edges is safely settled
	task pin(input logic v);
		@(posedge clk_i);
		modulating_input_i <= v;
		repeat (3) @(posedge clk_i);
	endtask
	task outs(input string n, input logic [3:0] x);
		@(negedge clk_i);
		chk(n, {28'h0, x}, {28'h0, output_d_o, output_c_o, output_b_o, output_a_o});
	endtask
	task irqc(input string n, input logic x);
		@(negedge clk_i);
		chk(n, {31'h0, x}, {31'h0, irq_o});
	endtask
	task finish_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		finish_test;
	end
	// ==========
	// Sequence
	initial begin
		logic [31:0] r;
		logic e;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("mode", 8'h00, 0);
		rd("steer", 8'h08, 0);
		outs("idle", 4'h0);
		apb(1'b0, 8'h24, 0, r, e);
		chk("slverr", 1, {31'h0, e});
		wr(8'h08, 32'ha5);
		rd("steer rw", 8'h08, 32'ha5);
		$display("registers done");
		wr(8'h08, 32'h5a);
		wr(8'h00, 32'h80);
		pin(1'b1);
		outs("steer hi", 4'hf);
		pin(1'b0);
		outs("steer lo", 4'h5);
		wr(8'h00, 32'h81);
		wr(8'h08, 32'h5f);
		repeat (3) @(posedge clk_i);
		outs("sync hold", 4'h5);
		pin(1'b1);
		outs("sync load", 4'hf);
		$display("steering done");
		wr(8'h04, 32'h4);
		wr(8'h00, 32'h84);
		pin(1'b1);
		outs("half hi", 4'h1);
		pin(1'b0);
		outs("half lo", 4'he);
		wr(8'h00, 32'h04);
		@(posedge clk_i);
		outs("off", 4'h4);
		wr(8'h04, 0);
		wr(8'h0c, 32'h83);
		wr(8'h00, 32'h84);
		pin(1'b1);
		outs("db gap", 4'h0);
		repeat (3) @(posedge clk_i);
		outs("db late", 4'h5);
		wr(8'h0c, 0);
		$display("half-bridge done");
		wr(8'h00, 32'h82);
		@(posedge clk_i);
		outs("fwd", 4'h9);
		wr(8'h0c, 32'h84);
		wr(8'h00, 32'h83);
		repeat (2) @(posedge clk_i);
		outs("dead", 4'h0);
		repeat (6) @(posedge clk_i);
		outs("rev", 4'h6);
		rd("status", 8'h18, 32'h4);
		rd("int", 8'h1c, 32'h4);
		irqc("irq masked", 1'b0);
		wr(8'h20, 32'h4);
		irqc("irq on", 1'b1);
		wr(8'h1c, 32'h4);
		irqc("irq clr", 1'b0);
		wr(8'h0c, 0);
		$display("full-bridge done");
		pin(1'b0);
		wr(8'h00, 32'h05);
		wr(8'h00, 32'h85);
		pin(1'b1);
		outs("pp first", 4'h5);
		pin(1'b0);
		pin(1'b1);
		outs("pp second", 4'ha);
		pin(1'b0);
		wr(8'h00, 32'h05);
		wr(8'h00, 32'h85);
		pin(1'b1);
		outs("pp restart", 4'h5);
		$display("push-pull done");
		wr(8'h00, 32'h84);
		wr(8'h14, 32'h32);
		trip <= 1'b1;
		repeat (4) @(posedge clk_i);
		outs("shut", 4'h3);
		rd("int shut", 8'h1c, 32'h1);
		trip <= 1'b0;
		repeat (2) @(posedge clk_i);
		wr(8'h18, 32'h1);
		repeat (2) @(posedge clk_i);
		outs("resume", 4'h5);
		$display("shutdown done");
		finish_test;
	end
endmodule
